// [btss_defs.svh]
// btss_defs.svh - offsets, field positions, reset values and counts
`ifndef BTSS_DEFS_SVH
`define BTSS_DEFS_SVH

`define BTSS_OFS_CTRL        8'h00
`define BTSS_OFS_STATUS      8'h04
`define BTSS_OFS_FRAME_SLOTS 8'h08
`define BTSS_OFS_WR_PTR      8'h0C
`define BTSS_OFS_SCRIPT_LEN  8'h10
`define BTSS_OFS_ENTRY_W0    8'h14
`define BTSS_OFS_ENTRY_W1    8'h18
`define BTSS_OFS_ENTRY_W2    8'h1C
`define BTSS_OFS_STREAM_DEF  8'h20
`define BTSS_OFS_LOOP_SEL    8'h24
`define BTSS_OFS_LOOP_COUNT  8'h28
`define BTSS_OFS_CHAN_STATE  8'h2C

`define BTSS_CTRL_RUN_BIT     0
`define BTSS_CTRL_RESTART_BIT 1
`define BTSS_ST_RUNNING_BIT   0
`define BTSS_ST_DONE_BIT      1
`define BTSS_ST_UNMUTED_BIT   2
`define BTSS_ST_PIF_BIT       3
`define BTSS_ST_ERR_NEST_BIT  4
`define BTSS_ST_ERR_STRM_BIT  5
`define BTSS_LOOP_INF_BIT     31

`define BTSS_FRAME_SLOTS_RST 12'h060
`define BTSS_SCRIPT_DEPTH    64
`define BTSS_LOOP_MAX        16
`define BTSS_CHANNELS        8

`define BTSS_CW_OPC_HI       15
`define BTSS_CW_OPC_LO       13
`define BTSS_CW_SSP_BIT      12
`define BTSS_OPC_PING        3'h0
`define BTSS_PING_WORD       16'h0000

`define BTSS_STREAM_NONE     2'h0
`define BTSS_STREAM_START    2'h1
`define BTSS_STREAM_STOP     2'h2

`endif

// [btss_link_partner.sv]
// far-side link clock source for the sequencer bench
`timescale 1ns/1ps
module btss_link_partner (
  input  wire logic enable,
  input  wire logic slow,
  output logic      link_clk
);
  // stands low while idle so no stray slot is seen between runs
  initial begin
    link_clk = 1'b0;
    #13;
    forever begin
      wait (enable === 1'b1);
      #(slow ? 320 : 160);
      link_clk = 1'b1;
      #(slow ? 320 : 160);
      link_clk = 1'b0;
    end
  end
endmodule

// [btss_pkg.sv]
// btss_pkg.sv - types shared by the script sequencer
package btss_pkg;

  typedef enum logic [1:0] {
    BTSS_IDLE = 2'b00,
    BTSS_ARM  = 2'b01,
    BTSS_PLAY = 2'b10,
    BTSS_DONE = 2'b11
  } btss_state_t;

  // one script frame entry, 96 bits = {word2, word1, word0}
  typedef struct packed {
    logic [7:0]  pad;
    logic [11:0] repeat_cnt;
    logic        ctrl_given;
    logic [15:0] ctrl_word;
    logic        parity_invalid;
    logic        err_en;
    logic        forced_slot_level;
    logic [11:0] first_forced_slot;
    logic [11:0] last_forced_slot;
    logic [1:0]  stream_op;
    logic [4:0]  stream_id;
    logic [7:0]  chan_mask;
    logic        pif_set;
    logic        pif_value;
    logic        ssp_set;
    logic [7:0]  ssp_period;
    logic        loop_begin;
    logic        loop_end;
    logic [3:0]  loop_idx;
  } btss_entry_t;

  typedef struct packed {
    logic        frame_start;
    logic        slot_strobe;
    logic [11:0] slot_num;
    logic        force_en;
    logic        force_level;
    logic [15:0] ctrl_word;
    logic        parity_invert;
    logic        ssp;
  } btss_frame_out_t;

  typedef struct packed {
    logic [7:0] chan_active;
    logic       dp_unmuted;
    logic       pulse_interface_enable;
  } btss_stream_out_t;

endpackage

// [bus_traffic_script_sequencer.sv]
// bus_traffic_script_sequencer.sv - script frame sequencer with AHB-Lite regs
`timescale 1ns/1ps
`include "btss_defs.svh"

// What this block does
// - during an error event, drive one level over the configured slot range
// - forced range is any slot span of the frame, one or more slots
// - error, stream and interface events execute only inside a frame
// - events of a frame entry are carried out while that frame plays
// - start feeds a stream into chosen channels; stop on same id ends it
// - stream id is letter A-D plus number and must be defined
// - hardware loop replays stored frames between markers for its count
// - loops are not nested; at most 16 loops in sequence
// - loop count 1 to 2147483647, or infinite
// - after period P, every P-th frame carries the sync point bit when its control word is a PING
// - period issued in frame M gives first sync point in frame M+P
// - after the period setting, repeated frames are played one by one
// - data ports stay muted until one sync point frame is seen
// - interface enable value 1 turns both interfaces on, 0 turns them off
// - each frame entry plays as many times as its repeat count, once for a count of 0
// - invalid parity marks the frame for inverted parity
// - every frame carries a control word, PING when none is given
module bus_traffic_script_sequencer (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire logic                     link_clk,
  output btss_pkg::btss_frame_out_t     frame_out,
  output btss_pkg::btss_stream_out_t    stream_out
);

  typedef struct packed {
    logic                   hw_sel;
    logic                   hw_write;
    logic [7:0]             hw_addr;
    logic                   run;
    logic [11:0]            frame_slots;
    logic [5:0]             wr_ptr;
    logic [6:0]             script_len;
    logic [31:0]            w0;
    logic [31:0]            w1;
    logic [31:0]            stream_def;
    logic [3:0]             loop_sel;
    logic                   err_nest;
    logic                   err_stream;
    logic                   sync1;
    logic                   sync2;
    logic                   sync3;
    btss_pkg::btss_state_t  fsm;
    logic [5:0]             ptr;
    logic [11:0]            rep_left;
    logic                   in_loop;
    logic [5:0]             loop_start;
    logic [30:0]            loop_left;
    logic                   loop_inf;
    logic                   ssp_on;
    logic [7:0]             ssp_period;
    logic [7:0]             ssp_cnt;
    logic [7:0][4:0]        chan_owner;
    btss_pkg::btss_frame_out_t  fo;
    btss_pkg::btss_stream_out_t so;
  } btss_regs_t;

  btss_regs_t             r_reg;
  btss_regs_t             r_next;
  btss_pkg::btss_entry_t  entry_mem [`BTSS_SCRIPT_DEPTH];
  logic [31:0]            loop_mem  [`BTSS_LOOP_MAX];
  logic                   mem_we;
  logic                   loop_we;
  btss_pkg::btss_entry_t  cur;
  btss_pkg::btss_entry_t  e;
  logic                   edge_seen;
  logic                   new_frame;
  logic                   fresh;
  logic                   jump;
  logic                   ssp_hit;
  logic [5:0]             p_next;
  logic [31:0]            lcount;
  logic [31:0]            rd;

  // a control word is a PING when its opcode field holds the PING code
  function automatic logic is_ping(input logic [15:0] w);
    is_ping = (w[`BTSS_CW_OPC_HI:`BTSS_CW_OPC_LO] == `BTSS_OPC_PING);
  endfunction

  function automatic logic in_range(input logic [11:0] s,
                                    input btss_pkg::btss_entry_t x);
    in_range = x.err_en && (s >= x.first_forced_slot)
               && (s <= x.last_forced_slot);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign frame_out  = r_reg.fo;
  assign stream_out = r_reg.so;
  assign cur = entry_mem[r_reg.ptr];
  assign lcount = loop_mem[e.loop_idx];

  always_comb begin
    rd = 32'h0000_0000;
    case (r_reg.hw_addr)
      `BTSS_OFS_CTRL:        rd[`BTSS_CTRL_RUN_BIT] = r_reg.run;
      `BTSS_OFS_STATUS: begin
        rd[`BTSS_ST_RUNNING_BIT] = (r_reg.fsm == btss_pkg::BTSS_PLAY);
        rd[`BTSS_ST_DONE_BIT]    = (r_reg.fsm == btss_pkg::BTSS_DONE);
        rd[`BTSS_ST_UNMUTED_BIT] = r_reg.so.dp_unmuted;
        rd[`BTSS_ST_PIF_BIT]     = r_reg.so.pulse_interface_enable;
        rd[`BTSS_ST_ERR_NEST_BIT] = r_reg.err_nest;
        rd[`BTSS_ST_ERR_STRM_BIT] = r_reg.err_stream;
        rd[13:8] = r_reg.ptr;
      end
      `BTSS_OFS_FRAME_SLOTS: rd[11:0] = r_reg.frame_slots;
      `BTSS_OFS_WR_PTR:      rd[5:0]  = r_reg.wr_ptr;
      `BTSS_OFS_SCRIPT_LEN:  rd[6:0]  = r_reg.script_len;
      `BTSS_OFS_ENTRY_W0:    rd = r_reg.w0;
      `BTSS_OFS_ENTRY_W1:    rd = r_reg.w1;
      `BTSS_OFS_STREAM_DEF:  rd = r_reg.stream_def;
      `BTSS_OFS_LOOP_SEL:    rd[3:0] = r_reg.loop_sel;
      `BTSS_OFS_LOOP_COUNT:  rd = loop_mem[r_reg.loop_sel];
      `BTSS_OFS_CHAN_STATE:  rd[7:0] = r_reg.so.chan_active;
      default:               rd = 32'h0000_0000;
    endcase
    hrdata = (r_reg.hw_sel && !r_reg.hw_write) ? rd : 32'h0000_0000;
  end

  always_comb begin
    r_next = r_reg;
    mem_we  = 1'b0;
    loop_we = 1'b0;
    new_frame = 1'b0;
    fresh = 1'b0;
    jump = 1'b0;
    ssp_hit = 1'b0;
    p_next = r_reg.ptr;
    r_next.fo.frame_start = 1'b0;
    r_next.fo.slot_strobe = 1'b0;
    // first flop feeds only the second; edges come from the later pair
    r_next.sync1 = link_clk;
    r_next.sync2 = r_reg.sync1;
    r_next.sync3 = r_reg.sync2;
    edge_seen = r_reg.sync2 && !r_reg.sync3;

    if (hready) begin
      r_next.hw_sel   = hsel && htrans[1];
      r_next.hw_addr  = haddr[7:0];
      r_next.hw_write = hwrite;
    end
    if (r_reg.hw_sel && r_reg.hw_write) begin
      case (r_reg.hw_addr)
        `BTSS_OFS_CTRL: begin
          r_next.run = hwdata[`BTSS_CTRL_RUN_BIT];
          if (hwdata[`BTSS_CTRL_RESTART_BIT]) begin
            r_next.fsm = btss_pkg::BTSS_IDLE;
          end
        end
        `BTSS_OFS_STATUS: begin
          if (hwdata[`BTSS_ST_ERR_NEST_BIT]) begin
            r_next.err_nest = 1'b0;
          end
          if (hwdata[`BTSS_ST_ERR_STRM_BIT]) begin
            r_next.err_stream = 1'b0;
          end
        end
        `BTSS_OFS_FRAME_SLOTS: r_next.frame_slots = hwdata[11:0];
        `BTSS_OFS_WR_PTR:      r_next.wr_ptr = hwdata[5:0];
        `BTSS_OFS_SCRIPT_LEN:  r_next.script_len = hwdata[6:0];
        `BTSS_OFS_ENTRY_W0:    r_next.w0 = hwdata;
        `BTSS_OFS_ENTRY_W1:    r_next.w1 = hwdata;
        `BTSS_OFS_ENTRY_W2: begin
          mem_we = 1'b1;
          r_next.wr_ptr = r_reg.wr_ptr + 6'h01;
        end
        `BTSS_OFS_STREAM_DEF:  r_next.stream_def = hwdata;
        `BTSS_OFS_LOOP_SEL:    r_next.loop_sel = hwdata[3:0];
        `BTSS_OFS_LOOP_COUNT:  loop_we = 1'b1;
        default: ;
      endcase
    end

    case (r_reg.fsm)
      btss_pkg::BTSS_IDLE: begin
        // a restart drops the stream outputs, sync, loop and forcing state; error flags stay set
        r_next.so = '0;
        r_next.ssp_on = 1'b0;
        r_next.in_loop = 1'b0;
        r_next.fo.force_en = 1'b0;
        if (r_reg.run && r_reg.script_len != 7'h00) begin
          r_next.fsm = btss_pkg::BTSS_ARM;
        end
      end
      btss_pkg::BTSS_ARM: begin
        if (edge_seen) begin
          new_frame = 1'b1;
          fresh = 1'b1;
          p_next = 6'h00;
          r_next.fsm = btss_pkg::BTSS_PLAY;
        end
      end
      btss_pkg::BTSS_PLAY: begin
        if (edge_seen) begin
          if (r_reg.fo.slot_num + 12'h001 < r_reg.frame_slots) begin
            // strobe only on a slot step; frame starts have their own pulse
            r_next.fo.slot_strobe = 1'b1;
            r_next.fo.slot_num = r_reg.fo.slot_num + 12'h001;
          end else if (r_reg.rep_left > 12'h001) begin
            new_frame = 1'b1;
            r_next.rep_left = r_reg.rep_left - 12'h001;
          end else if (cur.loop_end && r_reg.in_loop
                       && (r_reg.loop_inf
                           || r_reg.loop_left > 31'h0000_0001)) begin
            new_frame = 1'b1;
            fresh = 1'b1;
            jump = 1'b1;
            p_next = r_reg.loop_start;
            if (!r_reg.loop_inf) begin
              r_next.loop_left = r_reg.loop_left - 31'h0000_0001;
            end
          end else begin
            if (cur.loop_end) begin
              r_next.in_loop = 1'b0;
            end
            if ({1'b0, r_reg.ptr} + 7'h01 >= r_reg.script_len) begin
              r_next.fsm = btss_pkg::BTSS_DONE;
              r_next.fo.force_en = 1'b0;
            end else begin
              new_frame = 1'b1;
              fresh = 1'b1;
              p_next = r_reg.ptr + 6'h01;
            end
          end
        end
      end
      btss_pkg::BTSS_DONE: begin
        r_next.fo.force_en = 1'b0;
        if (!r_reg.run) begin
          r_next.fsm = btss_pkg::BTSS_IDLE;
        end
      end
      default: r_next.fsm = btss_pkg::BTSS_IDLE;
    endcase

    e = entry_mem[p_next];
    if (new_frame) begin
      r_next.fo.slot_num = 12'h000;
      r_next.fo.frame_start = 1'b1;
      // sync point counted per played frame, so repeats expand
      if (r_reg.ssp_on) begin
        if (r_reg.ssp_cnt + 8'h01 >= r_reg.ssp_period) begin
          ssp_hit = 1'b1;
          r_next.ssp_cnt = 8'h00;
        end else begin
          r_next.ssp_cnt = r_reg.ssp_cnt + 8'h01;
        end
      end
      if (fresh) begin
        // events are applied on the first play of the frame that holds them; loop begin is skipped on a loop jump
        r_next.ptr = p_next;
        r_next.rep_left = (e.repeat_cnt == 12'h000) ? 12'h001
                                                   : e.repeat_cnt;
        if (e.loop_begin && !jump) begin
          if (r_next.in_loop) begin
            r_next.err_nest = 1'b1;
          end else begin
            r_next.in_loop = 1'b1;
            r_next.loop_start = p_next;
            r_next.loop_inf = lcount[`BTSS_LOOP_INF_BIT];
            r_next.loop_left = (lcount[30:0] == 31'h0000_0000)
                               ? 31'h0000_0001 : lcount[30:0];
          end
        end
        if (e.ssp_set) begin
          // the setting frame is frame M; first hit lands on M+P
          r_next.ssp_on = (e.ssp_period != 8'h00);
          r_next.ssp_period = e.ssp_period;
          r_next.ssp_cnt = 8'h00;
          ssp_hit = 1'b0;
        end
        if (e.pif_set) begin
          r_next.so.pulse_interface_enable = e.pif_value;
        end
        if (e.stream_op != `BTSS_STREAM_NONE) begin
          if (!r_reg.stream_def[e.stream_id]) begin
            r_next.err_stream = 1'b1;
          end else begin
            for (int c = 0; c < `BTSS_CHANNELS; c++) begin
              if (e.stream_op == `BTSS_STREAM_START && e.chan_mask[c]) begin
                r_next.so.chan_active[c] = 1'b1;
                r_next.chan_owner[c] = e.stream_id;
              end
              if (e.stream_op == `BTSS_STREAM_STOP
                  && r_reg.chan_owner[c] == e.stream_id) begin
                r_next.so.chan_active[c] = 1'b0;
              end
            end
          end
        end
      end
      // the serializer computes parity; we only flag inversion
      r_next.fo.parity_invert = e.parity_invalid;
      r_next.fo.ctrl_word = e.ctrl_given ? e.ctrl_word
                                         : `BTSS_PING_WORD;
      r_next.fo.ssp = 1'b0;
      if (is_ping(r_next.fo.ctrl_word)) begin
        r_next.fo.ctrl_word[`BTSS_CW_SSP_BIT] = ssp_hit;
        r_next.fo.ssp = ssp_hit;
        if (ssp_hit) begin
          r_next.so.dp_unmuted = 1'b1;
        end
      end
    end

    if (r_next.fsm == btss_pkg::BTSS_PLAY
        && (new_frame || r_next.fo.slot_strobe)) begin
      r_next.fo.force_en = in_range(r_next.fo.slot_num,
                                    entry_mem[r_next.ptr]);
      r_next.fo.force_level = entry_mem[r_next.ptr].forced_slot_level;
    end
    if (!r_reg.run && r_reg.fsm != btss_pkg::BTSS_DONE) begin
      r_next.fsm = btss_pkg::BTSS_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.frame_slots <= `BTSS_FRAME_SLOTS_RST;
      r_reg.fsm <= btss_pkg::BTSS_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // script and loop stores have no reset: software fills them before a run
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      entry_mem[r_reg.wr_ptr] <= {hwdata, r_reg.w1, r_reg.w0};
    end
    if (loop_we) begin
      loop_mem[r_reg.loop_sel] <= hwdata;
    end
  end

endmodule

// [bus_traffic_script_sequencer_asserts.sv]
// concurrent port checks for the script sequencer
`timescale 1ns/1ps
module btss_asserts (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic [31:0]                hrdata,
  input wire logic                       link_clk,
  input wire btss_pkg::btss_frame_out_t  frame_out,
  input wire btss_pkg::btss_stream_out_t stream_out
);
  logic       rd_ph;
  logic       lprev;
  logic [3:0] lage;

  // age of the last raw link rise; saturates so a stalled link reads old
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph <= 1'b0;
      lprev <= 1'b0;
      lage  <= 4'hF;
    end else begin
      rd_ph <= hsel && htrans[1] && !hwrite && hready;
      lprev <= link_clk;
      if (link_clk && !lprev) lage <= 4'h0;
      else if (lage != 4'hF) lage <= lage + 4'h1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_BUS_OKAY:
    assert property (hreadyout && !hresp) else $error("bus not okay");
  AST_RD_IDLE:
    assert property (!rd_ph |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  AST_START_SLOT0:
    assert property (frame_out.frame_start |-> frame_out.slot_num == 12'h0)
    else $error("frame start not at slot zero");
  AST_SLOT_STEP:
    assert property (frame_out.slot_strobe |->
      frame_out.slot_num == $past(frame_out.slot_num) + 12'h1)
    else $error("slot number skipped");
  AST_START_PULSE:
    assert property (frame_out.frame_start |=> !frame_out.frame_start [*2])
    else $error("frame start too long");
  AST_SSP_PING:
    assert property (frame_out.frame_start && frame_out.ssp |->
      frame_out.ctrl_word[15:12] == 4'h1)
    else $error("sync point not in ping word");
  AST_UNMUTE:
    assert property (frame_out.frame_start && frame_out.ssp |->
      ##[0:4] stream_out.dp_unmuted)
    else $error("sync point did not unmute");
  AST_UNMUTE_CAUSE:
    assert property ($rose(stream_out.dp_unmuted) |->
      frame_out.ssp || $past(frame_out.ssp))
    else $error("unmute without sync point");
  AST_FRAME_HOLD:
    assert property (frame_out.slot_strobe |->
      $stable(frame_out.ctrl_word) && $stable(frame_out.parity_invert))
    else $error("frame fields moved mid frame");
  AST_LINK_CAUSE:
    assert property (frame_out.frame_start || frame_out.slot_strobe |->
      lage inside {[4'h1:4'h8]})
    else $error("slot without link edge");
endmodule

bind bus_traffic_script_sequencer btss_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
  .frame_out(frame_out), .stream_out(stream_out)
);

// [bus_traffic_script_sequencer_tb_top.sv]
// self-checking bench for the script sequencer
`timescale 1ns/1ps
`include "btss_defs.svh"
module bus_traffic_script_sequencer_tb_top;
  typedef struct packed {
    logic [15:0] cw;
    logic        pinv;
    logic        ssp;
    logic [7:0]  fmask;
    logic        lvl;
    logic [7:0]  chan;
    logic        pif;
    logic        unm;
  } btss_exp_t;
  localparam int NS = 8;
  logic                       hclk;
  logic                       hresetn = 1'b0;
  logic                       hsel = 1'b0;
  logic                       hwrite = 1'b0;
  logic [1:0]                 htrans = 2'b00;
  logic [2:0]                 hsize = 3'h2;
  logic [31:0]                haddr = 32'h0;
  logic [31:0]                hwdata = 32'h0;
  logic                       link_en = 1'b0;
  logic                       link_slow = 1'b0;
  logic                       hreadyout, hresp, link_clk, rd_ph;
  logic [31:0]                hrdata;
  logic [7:0]                 fmask, chm;
  logic [63:0]                rdn;
  btss_pkg::btss_frame_out_t  fo;
  btss_pkg::btss_stream_out_t so;
  btss_exp_t                  cur;
  btss_exp_t                  fq[$];
  logic [63:0]                rq[$];
  int                         miscompares = 0;
  int                         n_tests = 0;
  int                         cyc = 0;
  int                         gidx = 0;
  int                         nframes = 0;

  bus_traffic_script_sequencer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link_clk(link_clk), .frame_out(fo), .stream_out(so)
  );
  btss_link_partner far_end (
    .enable(link_en), .slow(link_slow), .link_clk(link_clk)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic report_and_stop;
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t read %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_fr(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t frame %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    rq.push_back({e, m});
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic load(input btss_pkg::btss_entry_t e);
    wr(`BTSS_OFS_ENTRY_W0, e[31:0]);
    wr(`BTSS_OFS_ENTRY_W1, e[63:32]);
    wr(`BTSS_OFS_ENTRY_W2, e[95:64]);
  endtask

  task automatic rnd_err(output logic [11:0] f, output logic [11:0] l,
                         output logic lv);
    f  = 12'($urandom_range(NS - 1));
    l  = f + 12'($urandom_range(NS - 1 - int'(f)));
    lv = 1'($urandom);
  endtask

  // one note per played frame; the sync period of 2 is set in frame 1
  task automatic exp_frames(input int n, input logic gv,
    input logic [15:0] cw, input logic pi, input logic er,
    input logic [11:0] f, input logic [11:0] l, input logic lv);
    btss_exp_t x;
    repeat (n) begin
      x.ssp  = !gv && gidx >= 3 && gidx % 2 == 1;
      x.cw   = gv ? cw : {3'h0, x.ssp, 12'h000};
      x.pinv = pi;
      x.lvl  = lv;
      for (int s = 0; s < NS; s++) x.fmask[s] = er && s >= f && s <= l;
      x.chan = gidx <= 1 ? chm : 8'h00;
      x.pif  = gidx >= 2 && gidx < 12;
      x.unm  = gidx >= 3;
      fq.push_back(x);
      gidx++;
    end
  endtask

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_ph <= 1'b0;
    else rd_ph <= hsel && htrans[1] && !hwrite;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  always @(negedge hclk) begin
    if (rd_ph === 1'b1) begin
      rdn = rq.pop_front();
      cmp_rd(hrdata & rdn[31:0], rdn[63:32]);
    end
    if (fo.frame_start === 1'b1) begin
      if (fq.size() == 0) begin
        cmp_fr(16'h1, 16'h0);
      end else begin
        cur = fq.pop_front();
        cmp_fr(fo.ctrl_word, cur.cw);
        cmp_fr(16'(fo.parity_invert), 16'(cur.pinv));
        cmp_fr(16'(fo.ssp), 16'(cur.ssp));
      end
      fmask = 8'h00;
    end
    if (fo.frame_start === 1'b1 || fo.slot_strobe === 1'b1) begin
      fmask[fo.slot_num[2:0]] = fo.force_en;
      if (fo.force_en === 1'b1)
        cmp_fr(16'(fo.force_level), 16'(cur.lvl));
      if (fo.slot_num === 12'(NS - 1)) begin
        cmp_fr(16'(fmask), 16'(cur.fmask));
        cmp_fr(16'(so.chan_active), 16'(cur.chan));
        cmp_fr(16'(so.pulse_interface_enable), 16'(cur.pif));
        cmp_fr(16'(so.dp_unmuted), 16'(cur.unm));
        nframes++;
      end
    end
  end

  initial begin
    btss_pkg::btss_entry_t e;
    logic [11:0]           f, l;
    logic                  lv;
    logic [15:0]           cw;
    void'($urandom(57));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`BTSS_OFS_FRAME_SLOTS, {20'h0, `BTSS_FRAME_SLOTS_RST}, 32'hFFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wr(`BTSS_OFS_FRAME_SLOTS, 32'(NS));
    rd(`BTSS_OFS_FRAME_SLOTS, 32'(NS), 32'hFFF);
    wr(`BTSS_OFS_WR_PTR, 32'h0);
    wr(`BTSS_OFS_STREAM_DEF, 32'h1);
    wr(`BTSS_OFS_LOOP_SEL, 32'h0);
    wr(`BTSS_OFS_LOOP_COUNT, 32'h2);
    chm = 8'($urandom) | 8'h01;
    rnd_err(f, l, lv);
    cw = {3'h3, 13'($urandom)};
    e = '{repeat_cnt: 12'h1, ctrl_given: 1'b1, ctrl_word: cw, err_en: 1'b1,
          forced_slot_level: lv, first_forced_slot: f,
          last_forced_slot: l, stream_op: `BTSS_STREAM_START,
          chan_mask: chm, default: '0};
    load(e);
    exp_frames(1, 1'b1, cw, 1'b0, 1'b1, f, l, lv);
    e = '{repeat_cnt: 12'h1, ssp_set: 1'b1, ssp_period: 8'h2, default: '0};
    load(e);
    exp_frames(1, 1'b0, cw, 1'b0, 1'b0, f, l, lv);
    rnd_err(f, l, lv);
    e = '{repeat_cnt: 12'h3, parity_invalid: 1'b1, err_en: 1'b1,
          forced_slot_level: lv, first_forced_slot: f,
          last_forced_slot: l, stream_op: `BTSS_STREAM_STOP,
          pif_set: 1'b1, pif_value: 1'b1, default: '0};
    load(e);
    exp_frames(3, 1'b0, cw, 1'b1, 1'b1, f, l, lv);
    // an undefined stream id inside the loop must leave channels alone
    e = '{repeat_cnt: 12'h7, loop_begin: 1'b1, chan_mask: 8'hFF,
          stream_op: `BTSS_STREAM_START, stream_id: 5'h09, default: '0};
    load(e);
    e = '{repeat_cnt: 12'h8, loop_end: 1'b1, pif_set: 1'b1, default: '0};
    load(e);
    repeat (2) begin
      exp_frames(7, 1'b0, cw, 1'b0, 1'b0, f, l, lv);
      exp_frames(8, 1'b0, cw, 1'b0, 1'b0, f, l, lv);
    end
    rd(`BTSS_OFS_WR_PTR, 32'h5, 32'h3F);
    wr(`BTSS_OFS_SCRIPT_LEN, 32'h5);
    wr(`BTSS_OFS_CTRL, 32'h1);
    link_en <= 1'b1;
    for (int i = 0; i < 15000 && nframes < 35; i++) begin
      @(posedge hclk);
      link_slow <= nframes >= 20;
    end
    // the last frame only ends on one more link edge, which moves to done
    @(posedge link_clk);
    @(posedge hclk);
    link_en <= 1'b0;
    repeat (40) @(posedge hclk);
    rd(`BTSS_OFS_STATUS, 32'h26, 32'h3E);
    wr(`BTSS_OFS_STATUS, 32'h30);
    rd(`BTSS_OFS_STATUS, 32'h0, 32'h30);
    wr(`BTSS_OFS_CTRL, 32'h0);
    wr(`BTSS_OFS_CTRL, 32'h2);
    rd(`BTSS_OFS_STATUS, 32'h0, 32'h0C);
    rd(`BTSS_OFS_CHAN_STATE, 32'h0, 32'hFF);
    repeat (2) @(posedge hclk);
    cmp_fr(16'(fq.size()), 16'h0);
    report_and_stop();
  end
endmodule
